// ### hw/ecc_pkg.sv
// Package of constants for the encoder channel control/status handshake
package ecc_pkg;
  // ******************************************************************
  // Control and status byte field positions
  // ******************************************************************
  localparam int unsigned MODE_BIT      = 7;  // Register mode select / acknowledge
  localparam int unsigned RW_BIT        = 6;  // Register access direction
  localparam int unsigned REGNO_MSB     = 5;  // Register number top bit
  localparam int unsigned GATE_BIT      = 4;  // Gate input level
  localparam int unsigned ZERO_LVL_BIT  = 3;  // Zero input level
  localparam int unsigned PRESET_BIT    = 2;  // Counter preset strobe / acknowledge
  localparam int unsigned LATSEL_BIT    = 1;  // Latched value select
  localparam int unsigned ZARM_BIT      = 0;  // Zero capture arm / done

  // ******************************************************************
  // Widths and reset values
  // ******************************************************************
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned REGNO_W       = 6;
  localparam logic [7:0]  STATUS_RST    = 8'h00;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;
endpackage : ecc_pkg

// ### hw/ecc_sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module ecc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // ******************************************************************
  // Synchroniser
  // ******************************************************************
  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // ecc_sync2
`default_nettype wire

// ### hw/ecc_channel.sv
// One channel: status byte generation, zero latch, preset and register access
`timescale 1ns/1ps
`default_nettype none
module ecc_channel
  import ecc_pkg::*;
#(
  parameter bit HAS_GATE_ZERO = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              exchange,
  input  wire logic [BYTE_W-1:0] ctrl,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              gate_s,
  input  wire logic              zero_s,
  input  wire logic [DATA_W-1:0] count,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output logic      [BYTE_W-1:0] status,
  output logic      [DATA_W-1:0] data_in,
  output logic                   preset_load,
  output logic                   reg_wr,
  output logic                   reg_rd,
  output logic      [REGNO_W-1:0] reg_addr
);
  logic              ctrl_preset_q;
  logic              zero_q;
  logic              done_q;
  logic [DATA_W-1:0] latch_q;

  // ******************************************************************
  // Decoding
  // ******************************************************************
  wire reg_mode   = ctrl[MODE_BIT];
  wire arm        = ctrl[ZARM_BIT] & HAS_GATE_ZERO;
  wire zero_rise  = zero_s & ~zero_q;
  wire capture    = ~reg_mode & arm & ~done_q & zero_rise;
  wire preset_rise= exchange & ~reg_mode & ctrl[PRESET_BIT] & ~ctrl_preset_q;
  wire [BYTE_W-1:0] pd_status = {1'b0, 2'b00,
                                 gate_s & HAS_GATE_ZERO,
                                 zero_s & HAS_GATE_ZERO,
                                 ctrl_preset_q,
                                 ctrl[LATSEL_BIT],
                                 done_q};
  wire [BYTE_W-1:0] rc_status = {1'b1, ctrl[RW_BIT], ctrl[REGNO_MSB:0]};

  // ******************************************************************
  // Zero latch and preset tracking
  // ******************************************************************
  // Done stays set until the arm bit is dropped; only the first edge captures
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_q        <= 1'b0;
      done_q        <= 1'b0;
      ctrl_preset_q <= 1'b0;
      latch_q       <= WORD_RST;
    end else begin
      zero_q <= zero_s;
      if (capture) begin
        done_q  <= 1'b1;
        latch_q <= count;
      end else if (!arm) begin
        done_q  <= 1'b0;
      end
      if (exchange) begin
        ctrl_preset_q <= ctrl[PRESET_BIT] & ~reg_mode;
      end
    end
  end

  // ******************************************************************
  // Process image answer, updated only at an exchange; strobes and register address written every clock
  // ******************************************************************
  // Answers take the control byte of the same exchange; the preset acknowledge and the done clear after a dropped arm bit lag by one exchange
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status      <= STATUS_RST;
      data_in     <= WORD_RST;
      preset_load <= 1'b0;
      reg_wr      <= 1'b0;
      reg_rd      <= 1'b0;
      reg_addr    <= '0;
    end else begin
      preset_load <= preset_rise;
      reg_wr      <= exchange & reg_mode & ctrl[RW_BIT];
      reg_rd      <= exchange & reg_mode & ~ctrl[RW_BIT];
      reg_addr    <= ctrl[REGNO_MSB:0];
      if (exchange) begin
        status <= reg_mode ? rc_status : pd_status;
        // Counter data is not reachable in register mode; word 0 carries register data
        data_in <= reg_mode ? reg_rdata :
                   (ctrl[LATSEL_BIT] ? latch_q : count);
      end
    end
  end
endmodule // ecc_channel
`default_nettype wire

// ### hw/ecc_top.sv
// Two-channel encoder control/status byte handshake
// Notes on behaviour
// - Process data mode reports status bit 7 zero
// - Status bit 4 shows gate input level
// - Status bit 3 shows zero input level
// - Status bit 2 acknowledges preset taken over
// - Status bit 1 echoes live or latched select
// - First zero rising edge latches counter, sets done
// - Drop arm, await done cleared, re-arm
// - Bit 6 read/write, bits 5:0 register number
// - Register mode reports status bit 7 one
// - Status echoes access type and register number
// - Counter data unavailable during register mode
// - Second channel identical to the first
// - Rising preset strobe loads counter from output
// - Latched select maps latch to input data
`timescale 1ns/1ps
`default_nettype none
module ecc_top
  import ecc_pkg::*;
#(
  parameter bit HAS_GATE_ZERO = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          exchange,
  input  wire logic [ecc_pkg::BYTE_W-1:0]    first_channel_control_byte,
  input  wire logic [ecc_pkg::BYTE_W-1:0]    second_channel_control_byte,
  input  wire logic [ecc_pkg::DATA_W-1:0]    first_data_out,
  input  wire logic [ecc_pkg::DATA_W-1:0]    second_data_out,
  input  wire logic [1:0]                    gate_pin,
  input  wire logic [1:0]                    zero_pin,
  input  wire logic [ecc_pkg::DATA_W-1:0]    first_count,
  input  wire logic [ecc_pkg::DATA_W-1:0]    second_count,
  input  wire logic [ecc_pkg::DATA_W-1:0]    first_reg_rdata,
  input  wire logic [ecc_pkg::DATA_W-1:0]    second_reg_rdata,
  output logic      [ecc_pkg::BYTE_W-1:0]    first_channel_status_byte,
  output logic      [ecc_pkg::BYTE_W-1:0]    second_channel_status_byte,
  output logic      [ecc_pkg::DATA_W-1:0]    first_data_in,
  output logic      [ecc_pkg::DATA_W-1:0]    second_data_in,
  output logic      [1:0]                    preset_load,
  output logic      [1:0]                    reg_wr,
  output logic      [1:0]                    reg_rd,
  output logic      [ecc_pkg::REGNO_W-1:0]   first_reg_addr,
  output logic      [ecc_pkg::REGNO_W-1:0]   second_reg_addr
);
  import ecc_pkg::*;

  logic [1:0] gate_s;
  logic [1:0] zero_s;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  ecc_sync2 #(.W(4)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({gate_pin, zero_pin}),
    .sync_out ({gate_s, zero_s})
  );

  // ******************************************************************
  // Channels, both built from the same logic
  // ******************************************************************
  // Identical instances keep the two byte layouts in step
  ecc_channel #(.HAS_GATE_ZERO(HAS_GATE_ZERO)) u_ch1 (
    .clk         (clk),
    .reset_n     (reset_n),
    .exchange    (exchange),
    .ctrl        (first_channel_control_byte),
    .data_out    (first_data_out),
    .gate_s      (gate_s[0]),
    .zero_s      (zero_s[0]),
    .count       (first_count),
    .reg_rdata   (first_reg_rdata),
    .status      (first_channel_status_byte),
    .data_in     (first_data_in),
    .preset_load (preset_load[0]),
    .reg_wr      (reg_wr[0]),
    .reg_rd      (reg_rd[0]),
    .reg_addr    (first_reg_addr)
  );

  ecc_channel #(.HAS_GATE_ZERO(HAS_GATE_ZERO)) u_ch2 (
    .clk         (clk),
    .reset_n     (reset_n),
    .exchange    (exchange),
    .ctrl        (second_channel_control_byte),
    .data_out    (second_data_out),
    .gate_s      (gate_s[1]),
    .zero_s      (zero_s[1]),
    .count       (second_count),
    .reg_rdata   (second_reg_rdata),
    .status      (second_channel_status_byte),
    .data_in     (second_data_in),
    .preset_load (preset_load[1]),
    .reg_wr      (reg_wr[1]),
    .reg_rd      (reg_rd[1]),
    .reg_addr    (second_reg_addr)
  );
endmodule // ecc_top
`default_nettype wire

// ### bench/ecc_host_model.sv
// Fieldbus controller model: control bytes and the exchange strobe
`timescale 1ns/1ps
`default_nettype none
module ecc_host_model (
  input  wire logic       req,
  input  wire logic [7:0] cb,
  output logic            exchange,
  output logic      [7:0] cb1,
  output logic      [7:0] cb2
);
  // Bytes stand from one exchange to the next; both channels get the same byte
  assign exchange = req;
  assign cb1      = cb;
  assign cb2      = cb;
endmodule // ecc_host_model
`default_nettype wire

// ### bench/ecc_monitor.sv
// Checker for the first channel of the control/status handshake
`timescale 1ns/1ps
`default_nettype none
module ecc_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        exchange,
  input wire logic [7:0]  first_channel_control_byte,
  input wire logic [7:0]  first_channel_status_byte,
  input wire logic [31:0] first_count,
  input wire logic [31:0] first_reg_rdata,
  input wire logic [31:0] first_data_in,
  input wire logic [1:0]  preset_load,
  input wire logic [1:0]  reg_wr,
  input wire logic [1:0]  reg_rd,
  input wire logic [5:0]  first_reg_addr
);
  // Short aliases keep each property on two lines
  wire logic [7:0] cb = first_channel_control_byte;
  wire logic [7:0] sb = first_channel_status_byte;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_proc_ack: assert property (exchange && !cb[7] |=> !sb[7] && sb[1] == $past(cb[1]))
    else $error("process mode status wrong");
  chk_reg_echo: assert property (exchange && cb[7] |=> sb == $past(cb))
    else $error("register mode status wrong");
  chk_preset_cause: assert property (preset_load[0] |-> $past(exchange) && $past(cb[2]) && !$past(cb[7]))
    else $error("preset without cause");
  chk_read_strobe: assert property (exchange && cb[7] && !cb[6] |=> reg_rd[0] && !reg_wr[0] && first_reg_addr == $past(cb[5:0]))
    else $error("read strobe wrong");
  chk_write_strobe: assert property (exchange && cb[7] && cb[6] |=> reg_wr[0] && !reg_rd[0] && first_reg_addr == $past(cb[5:0]))
    else $error("write strobe wrong");
  chk_live_data: assert property (exchange && !cb[7] && !cb[1] |=> first_data_in == $past(first_count))
    else $error("live count not shown");
  chk_reg_data: assert property (exchange && cb[7] |=> first_data_in == $past(first_reg_rdata))
    else $error("register data not shown");
  chk_status_stands: assert property (!exchange |=> $stable(sb) && $stable(first_data_in))
    else $error("status changed between exchanges");
endmodule // ecc_monitor
bind ecc_top ecc_monitor mon_u (.*);
`default_nettype wire

// ### bench/ecc_top_tb_top.sv
// Self-checking bench for the two-channel control/status handshake
`timescale 1ns/1ps
`default_nettype none
module ecc_top_tb_top;
  import ecc_pkg::*;
`define CMP(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, e); end end
  typedef struct { logic [7:0] c; logic g; logic z; logic [7:0] s; } ecc_row_s;
  logic        clk = 1'b0, reset_n = 1'b0, req = 1'b0, ex;
  logic [7:0]  cb = 8'h00, st1, st2, cb1, cb2, rc;
  logic [1:0]  gate = 2'h0, zero = 2'h0, pl, wr, rd;
  logic [31:0] cnt = 32'h1111_1111, rdat = 32'hA5A5_0F0F, dout = 32'h0BAD_F00D, din1, din2;
  logic [5:0]  ra1, ra2;
  int          bad_count = 0, comparisons = 0;
  // Rows: control byte, gate level, zero level, expected status
  ecc_row_s rows [8] = '{'{8'h00, 1'b0, 1'b0, 8'h00}, '{8'h00, 1'b1, 1'b0, 8'h10},
    '{8'h00, 1'b0, 1'b1, 8'h08}, '{8'h85, 1'b1, 1'b0, 8'h85}, '{8'hC5, 1'b0, 1'b0, 8'hC5},
    '{8'hBF, 1'b0, 1'b0, 8'hBF}, '{8'hFF, 1'b0, 1'b0, 8'hFF}, '{8'h00, 1'b0, 1'b0, 8'h00}};
  always #2.5 clk = ~clk;
  ecc_host_model host_u (.req(req), .cb(cb), .exchange(ex), .cb1(cb1), .cb2(cb2));
  ecc_top dut_u (.clk(clk), .reset_n(reset_n), .exchange(ex),
    .first_channel_control_byte(cb1), .second_channel_control_byte(cb2),
    .first_data_out(dout), .second_data_out(dout), .gate_pin(gate), .zero_pin(zero),
    .first_count(cnt), .second_count(cnt), .first_reg_rdata(rdat), .second_reg_rdata(rdat),
    .first_channel_status_byte(st1), .second_channel_status_byte(st2),
    .first_data_in(din1), .second_data_in(din2), .preset_load(pl), .reg_wr(wr),
    .reg_rd(rd), .first_reg_addr(ra1), .second_reg_addr(ra2));
  // One exchange; returns at the falling edge where the answer has settled
  task automatic xchg(input logic [7:0] c);
    @(negedge clk);
    cb  = c;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
  endtask
  // Both channels must answer alike
  task automatic chk(input logic [7:0] s, input logic [31:0] d);
    `CMP({st1, din1}, {s, d})
    `CMP({st2, din2}, {s, d})
  endtask
  task automatic conclude;
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(negedge clk);
    `CMP({st1, pl, wr, rd}, 14'h0000)
    reset_n = 1'b1;
    foreach (rows[i]) begin
      gate = {2{rows[i].g}};
      zero = {2{rows[i].z}};
      repeat (3) @(negedge clk);
      xchg(rows[i].c);
      chk(rows[i].s, rows[i].c[7] ? rdat : cnt);
      // Strobes still stand here; the address follows the byte every clock
      rc = rows[i].c;
      `CMP({wr, rd, ra1, ra2}, {{2{rc[7] & rc[6]}}, {2{rc[7] & ~rc[6]}}, rc[5:0], rc[5:0]})
    end
    xchg(8'h04);
    `CMP(pl, 2'h3)
    xchg(8'h04);
    chk(8'h04, cnt);
    `CMP(pl, 2'h0)
    xchg(8'h80);
    xchg(8'h84);
    `CMP(pl, 2'h0)
    xchg(8'h00);
    cnt = 32'h0000_1234;
    xchg(8'h01);
    zero = 2'h3;
    repeat (5) @(negedge clk);
    cnt  = 32'h0000_5678;
    zero = 2'h0;
    repeat (3) @(negedge clk);
    zero = 2'h3;
    repeat (5) @(negedge clk);
    xchg(8'h03);
    chk(8'h0B, 32'h0000_1234);
    zero = 2'h0;
    repeat (3) @(negedge clk);
    // Done drops one exchange after the arm bit goes low, so poll twice
    xchg(8'h00);
    chk(8'h01, cnt);
    xchg(8'h00);
    chk(8'h00, cnt);
    xchg(8'h01);
    zero = 2'h3;
    repeat (5) @(negedge clk);
    xchg(8'h03);
    chk(8'h0B, cnt);
    zero    = 2'h0;
    reset_n = 1'b0;
    @(negedge clk);
    chk(8'h00, 32'h0000_0000);
    reset_n = 1'b1;
    xchg(8'h00);
    chk(8'h00, cnt);
    conclude();
  end
  // Watchdog well beyond the 88 cycles (440 ns) of the sequence
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule // ecc_top_tb_top
`default_nettype wire
